//--- core/ppcmd_regs.vh
// constants for the prom programmer read and status command block
`ifndef PPCMD_REGS_VH
`define PPCMD_REGS_VH
`define PPCMD_CLK_MHZ 125
`define PPCMD_TIMEOUT_US 3000
`define PPCMD_TIMEOUT_CYC (`PPCMD_TIMEOUT_US * `PPCMD_CLK_MHZ)
`define PPCMD_CNT_W 19
`define PPCMD_ALL_ONES 8'hFF
`define PPCMD_ZERO8 8'h00
// device status byte bit positions
`define PPCMD_DS_READY 0
`define PPCMD_DS_PRESENT 1
`define PPCMD_DS_ILLEGAL 2
`define PPCMD_DS_TIMEOUT 3
// operation status byte bit positions, as presented by the programmer
`define PPCMD_OS_BUSY 0
`define PPCMD_OS_COMPLETE 1
`define PPCMD_OS_FAIL 2
`define PPCMD_OS_PROG_ERR 3
`define PPCMD_OS_ADDR_ERR 4
`define PPCMD_OS_HW_FAIL 5
`define PPCMD_OS_BOARD_ERR 6
`define PPCMD_OS_MOD_TIMEOUT 7
`endif

//--- core/ppcmd_timer.v
// three millisecond command timer
`timescale 1ns/1ps
`default_nettype none
`include "ppcmd_regs.vh"
module ppcmd_timer #(
  parameter [`PPCMD_CNT_W-1:0] LIMIT = `PPCMD_TIMEOUT_CYC
) (
  input wire clk,
  input wire rst_b,
  input wire start,
  input wire run,
  output reg expired
);
  reg [`PPCMD_CNT_W-1:0] count;
  always @(posedge clk) begin
    if (!rst_b) begin
      count <= {`PPCMD_CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (start) begin
      count <= {`PPCMD_CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (run && !expired) begin
      if (count >= LIMIT - 1'b1) begin
        expired <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- core/ppcmd_top.v
// polled data read and programmer status command engine
`timescale 1ns/1ps
`default_nettype none
`include "ppcmd_regs.vh"
module ppcmd_top #(
  parameter [`PPCMD_CNT_W-1:0] TIMEOUT_CYCLES = `PPCMD_TIMEOUT_CYC
) (
  input wire CLOCK,
  input wire RST_B,
  input wire POLLED_DATA_READ_CMD,
  input wire PROGRAMMER_STATUS_CMD,
  input wire HOST_READ,
  input wire PROGRAMMER_ACKNOWLEDGE,
  input wire [7:0] PROGRAMMER_READ_LINES,
  input wire PROGRAMMER_ATTACHED,
  input wire PROGRAMMER_POWERED,
  output reg PROGRAMMER_READ_STROBE_ZERO,
  output reg PROGRAMMER_READ_STROBE_ONE,
  output reg [7:0] HOST_DATA_BUFFER,
  output reg OUTPUT_FULL_FLAG,
  output reg COMMAND_DATA_FLAG,
  output reg [7:0] DEVICE_STATUS
);
  localparam [2:0] ST_IDLE = 3'b000;
  localparam [2:0] ST_DATA = 3'b001;
  localparam [2:0] ST_OPST = 3'b010;
  localparam [2:0] ST_WAIT = 3'b011;
  localparam [2:0] ST_DEVST = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] next_buffer;
  reg next_full;
  reg ready;
  reg illegal;
  reg stuck;
  wire expired;

  ////////////////////////////////////////////////////////////////////////
  // the strobe states are the only ones in which the programmer may answer
  function is_open;
    input [2:0] st;
    begin
      is_open = (st == ST_DATA) || (st == ST_OPST);
    end
  endfunction

  // bit positions sit in the header so host code can share them; the bench uses literal masks
  function [7:0] pack_status;
    input r;
    input p;
    input i;
    input t;
    begin
      pack_status = `PPCMD_ZERO8;
      pack_status[`PPCMD_DS_READY] = r;
      pack_status[`PPCMD_DS_PRESENT] = p;
      pack_status[`PPCMD_DS_ILLEGAL] = i;
      pack_status[`PPCMD_DS_TIMEOUT] = t;
    end
  endfunction

  wire present = PROGRAMMER_ATTACHED & PROGRAMMER_POWERED;
  wire new_cmd = POLLED_DATA_READ_CMD | PROGRAMMER_STATUS_CMD;
  wire accept = new_cmd && (state == ST_IDLE);
  wire open_cmd = is_open(state);
  wire take = open_cmd && PROGRAMMER_ACKNOWLEDGE;
  // an ack wins over a timeout that falls in the same cycle
  wire abort = open_cmd && !PROGRAMMER_ACKNOWLEDGE && (expired || !present);
  wire closing = (state == ST_DEVST);
  wire load = take || abort || closing;
  // an absent unit reads as timed out without waiting for the timer
  wire timeout_bit = stuck | ~present;

  ////////////////////////////////////////////////////////////////////////
  // timer restarts on each accepted command and runs in every state except ST_IDLE
  ppcmd_timer #(
    .LIMIT(TIMEOUT_CYCLES)
  ) u_timer (
    .clk(CLOCK),
    .rst_b(RST_B),
    .start(accept),
    .run(state != ST_IDLE),
    .expired(expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // polling mode setup is the host's job; the engine trusts it
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (POLLED_DATA_READ_CMD) begin
          next_state = ST_DATA;
        end else if (PROGRAMMER_STATUS_CMD) begin
          next_state = ST_OPST;
        end
      end
      ST_DATA: begin
        if (take || abort) begin
          next_state = ST_IDLE;
        end
      end
      ST_OPST: begin
        if (take) begin
          next_state = ST_WAIT;
        end else if (abort) begin
          next_state = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (!OUTPUT_FULL_FLAG) begin
          next_state = ST_DEVST;
        end
      end
      ST_DEVST: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // operation status is always on the lines outside data reads
  always @* begin
    next_buffer = HOST_DATA_BUFFER;
    if (take) begin
      next_buffer = PROGRAMMER_READ_LINES;
    end else if (abort) begin
      next_buffer = `PPCMD_ALL_ONES;
    end else if (closing) begin
      next_buffer = pack_status(1'b1, present, illegal, timeout_bit);
    end
  end

  // a load beats a host read in the same cycle, so no fresh byte is lost
  always @* begin
    next_full = OUTPUT_FULL_FLAG;
    if (HOST_READ) begin
      next_full = 1'b0;
    end
    if (load) begin
      next_full = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge CLOCK) begin
    if (!RST_B) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge CLOCK) begin
    if (!RST_B) begin
      ready <= 1'b1;
      illegal <= 1'b0;
      stuck <= 1'b0;
      DEVICE_STATUS <= `PPCMD_ZERO8;
    end else begin
      DEVICE_STATUS <= pack_status(ready, present, illegal, timeout_bit);
      if (accept) begin
        ready <= 1'b0;
        illegal <= 1'b0;
        stuck <= 1'b0;
      end else begin
        // a command that is not accepted can only arrive while busy
        if (new_cmd) begin
          illegal <= 1'b1;
        end
        if ((take && state == ST_DATA) || closing) begin
          ready <= 1'b1;
        end
        if (abort || (state == ST_WAIT && expired)) begin
          stuck <= 1'b1;
        end
      end
    end
  end

  // one strobe stands from accept until the answer, the timeout or loss of the unit
  always @(posedge CLOCK) begin
    if (!RST_B) begin
      PROGRAMMER_READ_STROBE_ZERO <= 1'b0;
      PROGRAMMER_READ_STROBE_ONE <= 1'b0;
    end else if (accept) begin
      PROGRAMMER_READ_STROBE_ZERO <= POLLED_DATA_READ_CMD;
      PROGRAMMER_READ_STROBE_ONE <= ~POLLED_DATA_READ_CMD;
    end else if (take || abort) begin
      PROGRAMMER_READ_STROBE_ZERO <= 1'b0;
      PROGRAMMER_READ_STROBE_ONE <= 1'b0;
    end
  end

  always @(posedge CLOCK) begin
    if (!RST_B) begin
      HOST_DATA_BUFFER <= `PPCMD_ZERO8;
      OUTPUT_FULL_FLAG <= 1'b0;
      COMMAND_DATA_FLAG <= 1'b0;
    end else begin
      HOST_DATA_BUFFER <= next_buffer;
      OUTPUT_FULL_FLAG <= next_full;
      if (accept) begin
        COMMAND_DATA_FLAG <= 1'b0;
      end else if (abort) begin
        COMMAND_DATA_FLAG <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/ppcmd_chk_asserts.sv
// assertion checker for the polled read and status command engine
`timescale 1ns/1ps
`default_nettype none
module ppcmd_chk (
  input wire CLOCK,
  input wire RST_B,
  input wire POLLED_DATA_READ_CMD,
  input wire PROGRAMMER_STATUS_CMD,
  input wire PROGRAMMER_ACKNOWLEDGE,
  input wire [7:0] PROGRAMMER_READ_LINES,
  input wire PROGRAMMER_ATTACHED,
  input wire PROGRAMMER_POWERED,
  input wire PROGRAMMER_READ_STROBE_ZERO,
  input wire PROGRAMMER_READ_STROBE_ONE,
  input wire [7:0] HOST_DATA_BUFFER,
  input wire OUTPUT_FULL_FLAG,
  input wire COMMAND_DATA_FLAG,
  input wire [7:0] DEVICE_STATUS
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  zero_cause_a: assert property (
    $rose(PROGRAMMER_READ_STROBE_ZERO) |-> $past(POLLED_DATA_READ_CMD))
    else $error("strobe zero without command");
  one_cause_a: assert property (
    $rose(PROGRAMMER_READ_STROBE_ONE) |-> $past(PROGRAMMER_STATUS_CMD))
    else $error("strobe one without command");
  data_load_a: assert property (
    PROGRAMMER_READ_STROBE_ZERO && PROGRAMMER_ACKNOWLEDGE |=>
    OUTPUT_FULL_FLAG && HOST_DATA_BUFFER == $past(PROGRAMMER_READ_LINES))
    else $error("data byte not loaded");
  status_load_a: assert property (
    PROGRAMMER_READ_STROBE_ONE && PROGRAMMER_ACKNOWLEDGE |=>
    OUTPUT_FULL_FLAG && HOST_DATA_BUFFER == $past(PROGRAMMER_READ_LINES))
    else $error("status byte not loaded");
  present_bit_a: assert property (
    $past(RST_B, 2) |->
    DEVICE_STATUS[1] == $past(PROGRAMMER_ATTACHED && PROGRAMMER_POWERED))
    else $error("present bit wrong");
  absent_timeout_a: assert property (
    $past(RST_B, 2) && !DEVICE_STATUS[1] |-> DEVICE_STATUS[3])
    else $error("timeout bit clear while absent");
  ones_load_a: assert property ($rose(COMMAND_DATA_FLAG) |->
    HOST_DATA_BUFFER == 8'hFF && OUTPUT_FULL_FLAG) else $error("timeout byte wrong");
  illegal_cause_a: assert property ($rose(DEVICE_STATUS[2]) |->
    $past(POLLED_DATA_READ_CMD || PROGRAMMER_STATUS_CMD) ||
    $past(POLLED_DATA_READ_CMD || PROGRAMMER_STATUS_CMD, 2)) else $error("illegal bit without command");
  cover property (PROGRAMMER_READ_STROBE_ONE && PROGRAMMER_ACKNOWLEDGE);
  cover property ($rose(COMMAND_DATA_FLAG));
  cover property ($rose(DEVICE_STATUS[2]));
  cover property ($rose(DEVICE_STATUS[3]) && DEVICE_STATUS[1]);
endmodule
bind ppcmd_top ppcmd_chk i_chk (.*);
`default_nettype wire

//--- verif/ppcmd_prog.sv
// behavioural programmer model facing the command engine
`timescale 1ns/1ps
`default_nettype none
module ppcmd_prog (
  input wire CLOCK,
  input wire strobe_zero,
  input wire strobe_one,
  input wire [7:0] data_byte,
  input wire [7:0] op_status,
  input wire stall,
  output reg ack,
  output wire [7:0] lines
);
  // data_byte stands for a read already finished in polling mode, busy clear
  // so the host may issue the polled data read at once
  // op_status carries busy, complete and fault bits set by the bench
  assign lines = strobe_zero ? data_byte : op_status;
  initial ack = 1'b0;
  // a stalled or absent unit never answers, so the engine must time out
  always @(posedge CLOCK) ack <= (strobe_zero | strobe_one) & ~ack & ~stall;
endmodule
`default_nettype wire

//--- verif/ppcmd_top_tb.sv
// self-checking bench for the polled read and status commands
`timescale 1ns/1ps
`default_nettype none
module ppcmd_top_tb;
  reg clock, rst_b = 0, rd_cmd = 0, st_cmd = 0, host_read = 0, attached = 1, stall = 0;
  reg [7:0] data_byte = 8'hA5, op_status = 8'h42;
  wire s0, s1, ack, full, cdf;
  wire [7:0] lines, buffer, dev_st;
  integer fail_count = 0, checked = 0;
  ppcmd_top #(.TIMEOUT_CYCLES(20)) i_dut (.CLOCK(clock), .RST_B(rst_b),
    .POLLED_DATA_READ_CMD(rd_cmd), .PROGRAMMER_STATUS_CMD(st_cmd), .HOST_READ(host_read),
    .PROGRAMMER_ACKNOWLEDGE(ack), .PROGRAMMER_READ_LINES(lines), .PROGRAMMER_ATTACHED(attached),
    .PROGRAMMER_POWERED(1'b1), .PROGRAMMER_READ_STROBE_ZERO(s0), .PROGRAMMER_READ_STROBE_ONE(s1),
    .HOST_DATA_BUFFER(buffer), .OUTPUT_FULL_FLAG(full), .COMMAND_DATA_FLAG(cdf),
    .DEVICE_STATUS(dev_st));
  ppcmd_prog i_prog (.CLOCK(clock), .strobe_zero(s0), .strobe_one(s1), .data_byte(data_byte),
    .op_status(op_status), .stall(stall | ~attached), .ack(ack), .lines(lines));
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  task complete_run;
    begin
      $display("mismatches %0d, checks %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        fail_count = fail_count + 1;
      end
    end
  endtask
  // holding a command for two edges makes the second edge a request while busy
  task cmd(input sel, input integer len);
    begin
      @(posedge clock);
      if (sel) rd_cmd <= 1'b1;
      else st_cmd <= 1'b1;
      repeat (len) @(posedge clock);
      rd_cmd <= 1'b0;
      st_cmd <= 1'b0;
    end
  endtask
  task hread;
    begin
      @(posedge clock);
      host_read <= 1'b1;
      @(posedge clock);
      host_read <= 1'b0;
    end
  endtask
  task wfull;
    integer n;
    begin
      n = 0;
      @(posedge clock);
      #1;
      while (full !== 1'b1 && n < 200) begin
        @(posedge clock);
        #1;
        n = n + 1;
      end
      if (n == 200) begin
        $display("wrong value at %0t: output full never set", $time);
        fail_count = fail_count + 1;
        complete_run;
      end
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk(dev_st, 8'h03);
    cmd(1, 1);
    wfull;
    chk(buffer, 8'hA5);
    hread;
    cmd(0, 1);
    wfull;
    chk(buffer, 8'h42);
    hread;
    wfull;
    chk(buffer, 8'h03);
    hread;
    cmd(0, 2);
    wfull;
    hread;
    wfull;
    chk(dev_st & 8'h04, 8'h04);
    chk(buffer, 8'h07);
    hread;
    // leave the first status byte unread past the timer limit
    cmd(0, 1);
    wfull;
    chk(buffer, 8'h42);
    repeat (30) @(posedge clock);
    hread;
    wfull;
    chk(buffer, 8'h0B);
    hread;
    @(posedge clock) stall <= 1'b1;
    cmd(1, 1);
    wfull;
    chk(buffer, 8'hFF);
    chk({7'h00, cdf}, 8'h01);
    @(posedge clock);
    #1;
    chk(dev_st & 8'h0A, 8'h0A);
    hread;
    @(posedge clock) attached <= 1'b0;
    cmd(0, 1);
    wfull;
    chk(buffer, 8'hFF);
    chk(dev_st & 8'h0A, 8'h08);
    hread;
    complete_run;
  end
endmodule
`default_nettype wire
